// *** rtl/tmrps_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tmrps_top
  import tmrps_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int PRESCALE_W = 8
)(
  // system
  input wire logic MCLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // shared count pin, two-way
  input wire logic EXT_PIN_I,
  output logic EXT_PIN_O,
  output logic EXT_PIN_OE_N,
  input wire logic PORT_LATCH,
  output logic [5:0] PIN_DIR,
  // comparator
  input wire logic COMP_RESULT,
  output logic [6:0] COMP_CTRL,
  // watchdog side of the prescaler
  input wire logic WDOG_TICK,
  input wire logic WDOG_CLEAR,
  output logic WDOG_TIMEOUT,
  // observed count
  output logic [7:0] COUNT_VALUE
);

  // registers
  logic [7:0] count_reg;
  tmrps_option_t option_reg;
  tmrps_cmp_t cmp_reg;
  logic [5:0] dir_reg;
  logic [31:0] prdata_reg;
  logic [1:0] hold_reg;
  tmrps_phase_t phase_reg;
  tmrps_phase_t phase_next;

  // synchronisers for the pin and the comparator result
  logic [1:0] async_in;
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] sync3_reg;
  logic [1:0] level_reg;

  // source path
  tmrps_mode_t mode;
  logic comp_out;
  logic src_level;
  logic src_adj;
  logic src_adj_d_reg;
  logic src_edge;
  logic pre_tap;
  logic pre_rise;
  logic pre_clr;
  logic pre_step;
  logic pre_on_counter;
  logic sampled_reg;
  logic sample_now;
  logic sample_val;
  logic cyc_tick;
  logic inc_evt;
  logic drive_comp;

  // bus decode
  logic [5:0] idx;
  logic setup;
  logic access;
  logic wr_en;
  logic mapped;
  logic count_wr;
  logic option_wr;
  logic cmp_wr;
  logic dir_wr;

  // apb decode; the slave never waits, so pready is tied high
  assign idx = PADDR[7:2];
  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE;
  assign wr_en = access & PWRITE & PSTRB[0];

  // decode of the five word slots
  always_comb
  begin
    mapped = 1'b0;
    unique case (idx)
      TMRPS_IDX_COUNT,
      TMRPS_IDX_CMP_SMALL,
      TMRPS_IDX_CMP_LARGE,
      TMRPS_IDX_OPTION,
      TMRPS_IDX_DIR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign count_wr = wr_en & (idx == TMRPS_IDX_COUNT);
  assign option_wr = wr_en & (idx == TMRPS_IDX_OPTION);
  assign cmp_wr = wr_en & ((idx == TMRPS_IDX_CMP_SMALL) | (idx == TMRPS_IDX_CMP_LARGE));
  assign dir_wr = wr_en & (idx == TMRPS_IDX_DIR);

  assign PREADY = 1'b1;
  assign PSLVERR = access & ~mapped;
  assign PRDATA = prdata_reg;

  // read data captured in the setup cycle so it stands through the access phase;
  // configuration and direction are write-only and read as zero
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      prdata_reg <= 32'h0000_0000;
    else if (setup & ~PWRITE)
    begin
      if (idx == TMRPS_IDX_COUNT)
        prdata_reg <= {24'h00_0000, count_reg};
      else if ((idx == TMRPS_IDX_CMP_SMALL) | (idx == TMRPS_IDX_CMP_LARGE))
        prdata_reg <= {24'h00_0000, comp_out, cmp_reg[6:0]};
      else
        prdata_reg <= 32'h0000_0000;
    end
  end

  // software registers
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      option_reg <= tmrps_option_t'(TMRPS_OPTION_RST);
    else if (option_wr)
      option_reg <= tmrps_option_t'(PWDATA[7:0]);
  end

  // bit 7 of the comparator word is the live result and is not stored
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      cmp_reg <= tmrps_cmp_t'(TMRPS_CMP_RST);
    else if (cmp_wr)
      cmp_reg <= tmrps_cmp_t'({1'b1, PWDATA[6:0]});
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      dir_reg <= TMRPS_DIR_RST;
    else if (dir_wr)
      dir_reg <= PWDATA[5:0];
  end

  // instruction cycle phases: one tick per cycle at the end of the fourth
  always_comb
  begin
    phase_next = TMRPS_Q1;
    unique case (phase_reg)
      TMRPS_Q1: phase_next = TMRPS_Q2;
      TMRPS_Q2: phase_next = TMRPS_Q3;
      TMRPS_Q3: phase_next = TMRPS_Q4;
      TMRPS_Q4: phase_next = TMRPS_Q1;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      phase_reg <= TMRPS_Q1;
    else
      phase_reg <= phase_next;
  end

  assign cyc_tick = (phase_reg == TMRPS_Q4);

  // pin and comparator pass three flops; a change counts once
  // the second and third agree
  assign async_in = {COMP_RESULT, EXT_PIN_I};

  for (genvar g = 0; g < 2; g++)
  begin : g_sync
    always_ff @(posedge MCLK or negedge RST_N)
    begin
      if (!RST_N)
      begin
        sync1_reg[g] <= 1'b0;
        sync2_reg[g] <= 1'b0;
        sync3_reg[g] <= 1'b0;
        level_reg[g] <= 1'b0;
      end
      else
      begin
        sync1_reg[g] <= async_in[g];
        sync2_reg[g] <= sync1_reg[g];
        sync3_reg[g] <= sync2_reg[g];
        if (sync2_reg[g] == sync3_reg[g])
          level_reg[g] <= sync3_reg[g];
      end
    end
  end

  // polarity bit set passes the result straight, clear inverts it
  assign comp_out = cmp_reg.polarity ? level_reg[1] : ~level_reg[1];

  // mode selection
  always_comb
  begin
    if (!option_reg.count_source_select)
      mode = TMRPS_TIMER;
    else if (!cmp_reg.comparator_timer_clock_select)
      mode = TMRPS_CMP_INTERNAL;
    else if (cmp_reg.comparator_pin_output_disable)
      mode = TMRPS_PIN_COUNT;
    else
      mode = TMRPS_CMP_ON_PIN;
  end

  // comparator-on-pin still counts through the pin input, so it sees
  // the pad's own delay just like an outside clock would
  always_comb
  begin
    src_level = level_reg[0];
    unique case (mode)
      TMRPS_TIMER: src_level = 1'b0;
      TMRPS_PIN_COUNT: src_level = level_reg[0];
      TMRPS_CMP_INTERNAL: src_level = comp_out;
      TMRPS_CMP_ON_PIN: src_level = level_reg[0];
    endcase
  end

  // falling edge select inverts the source so a rise is always counted
  assign src_adj = src_level ^ option_reg.count_edge_select;

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      src_adj_d_reg <= 1'b1; // idle level of the adjusted source, so reset makes no edge
    else
      src_adj_d_reg <= src_adj;
  end

  assign src_edge = src_adj & ~src_adj_d_reg;

  // shared prescaler: serves the counter or the watchdog, never both
  assign pre_on_counter = ~option_reg.prescaler_assignment;

  always_comb
  begin
    if (!pre_on_counter)
      pre_step = WDOG_TICK;
    else if (mode == TMRPS_TIMER)
      pre_step = cyc_tick;
    else
      pre_step = src_edge;
  end

  assign pre_clr = (count_wr & pre_on_counter) | (WDOG_CLEAR & ~pre_on_counter);

  tmrps_prescale #(
    .WIDTH(PRESCALE_W)
  ) u_prescale (
    .clk(MCLK),
    .rst_n(RST_N),
    .clr(pre_clr),
    .step(pre_step),
    .ratio(option_reg.prescale_ratio),
    .tap(pre_tap),
    .tap_rise(pre_rise)
  );

  // watchdog gets the undivided tick when the prescaler is with the counter
  assign WDOG_TIMEOUT = pre_on_counter ? WDOG_TICK : pre_rise;

  // external source sampled at the second and fourth phase; a rise
  // between two samples requests one increment
  assign sample_now = (phase_reg == TMRPS_Q2) | (phase_reg == TMRPS_Q4);
  assign sample_val = pre_on_counter ? pre_tap : src_adj;

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      sampled_reg <= 1'b1; // a zero here would count a phantom edge right after reset
    else if (sample_now)
      sampled_reg <= sample_val;
  end

  always_comb
  begin
    if (mode == TMRPS_TIMER)
      inc_evt = cyc_tick & (pre_on_counter ? pre_rise : 1'b1);
    else
      inc_evt = sample_now & sample_val & ~sampled_reg;
  end

  // write hold: two instruction cycles without counting after a write
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      hold_reg <= 2'h0;
    else if (count_wr)
      hold_reg <= TMRPS_WRITE_HOLD;
    else if (cyc_tick && hold_reg != 2'h0)
      hold_reg <= hold_reg - 2'h1;
  end

  // the count itself; a write wins over an increment in the same cycle
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      count_reg <= TMRPS_COUNT_RST;
    else if (count_wr)
      count_reg <= PWDATA[7:0];
    else if (inc_evt && hold_reg == 2'h0)
      count_reg <= count_reg + 8'h01;
  end

  assign COUNT_VALUE = count_reg;

  // pin drive: source select set forces the pin to input, except
  // that the comparator may drive it and still be read back
  assign drive_comp = (mode == TMRPS_CMP_ON_PIN);

  always_comb
  begin
    if (option_reg.count_source_select)
    begin
      EXT_PIN_OE_N = ~drive_comp;
      EXT_PIN_O = drive_comp ? comp_out : 1'b0;
    end
    else
    begin
      EXT_PIN_OE_N = dir_reg[TMRPS_DIR_PIN_BIT];
      EXT_PIN_O = PORT_LATCH;
    end
  end

  // direction of the port with the count pin forced to input in counter modes, and to output when the comparator drives it
  always_comb
  begin
    PIN_DIR = dir_reg;
    if (option_reg.count_source_select)
      PIN_DIR[TMRPS_DIR_PIN_BIT] = ~drive_comp;
  end

  assign COMP_CTRL = cmp_reg[6:0];

endmodule
`default_nettype wire

// *** rtl/tmrps_pkg.sv ***
package tmrps_pkg;

  // register indices on the bus; byte address is four times the index
  localparam logic [5:0] TMRPS_IDX_COUNT = 6'h01;
  localparam logic [5:0] TMRPS_IDX_CMP_SMALL = 6'h07;
  localparam logic [5:0] TMRPS_IDX_CMP_LARGE = 6'h08;
  localparam logic [5:0] TMRPS_IDX_OPTION = 6'h10;
  localparam logic [5:0] TMRPS_IDX_DIR = 6'h11;

  // reset values
  localparam logic [7:0] TMRPS_COUNT_RST = 8'h00;
  localparam logic [7:0] TMRPS_OPTION_RST = 8'hff;
  localparam logic [7:0] TMRPS_CMP_RST = 8'hff;
  localparam logic [5:0] TMRPS_DIR_RST = 6'h3f;

  // direction bit that belongs to the shared count pin
  localparam int TMRPS_DIR_PIN_BIT = 2;

  // timing: clock periods per instruction cycle, cycles of count hold after a write
  localparam int TMRPS_TOSC_NS = 20;
  localparam int TMRPS_INSTR_NS = 80;
  localparam int TMRPS_PHASES = TMRPS_INSTR_NS / TMRPS_TOSC_NS;
  localparam logic [1:0] TMRPS_WRITE_HOLD = 2'h2;

  // configuration register layout, bit 7 first
  typedef struct packed {
    logic wake_dis;
    logic pullup_dis;
    logic count_source_select;
    logic count_edge_select;
    logic prescaler_assignment;
    logic [2:0] prescale_ratio;
  } tmrps_option_t;

  // comparator control layout, bit 7 first; bit 7 is read-only
  typedef struct packed {
    logic comparator_result;
    logic comparator_pin_output_disable;
    logic polarity;
    logic comparator_timer_clock_select;
    logic enable;
    logic neg_ref;
    logic pos_ref;
    logic wake_dis;
  } tmrps_cmp_t;

  // instruction cycle phases
  typedef enum logic [1:0] {
    TMRPS_Q1,
    TMRPS_Q2,
    TMRPS_Q3,
    TMRPS_Q4
  } tmrps_phase_t;

  // count source selection
  typedef enum logic [1:0] {
    TMRPS_TIMER,
    TMRPS_PIN_COUNT,
    TMRPS_CMP_INTERNAL,
    TMRPS_CMP_ON_PIN
  } tmrps_mode_t;

endpackage

// *** rtl/tmrps_prescale.sv ***
`timescale 1ns/100ps
`default_nettype none
module tmrps_prescale
  import tmrps_pkg::*;
#(
  parameter int WIDTH = 8
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic clr,
  input wire logic step,
  input wire logic [2:0] ratio,
  // output
  output logic tap,
  output logic tap_rise
);

  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;

  // bit n toggles every 2^n steps, so bit n divides by 2^(n+1)
  assign cnt_next = cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
  assign tap = cnt_reg[ratio];
  assign tap_rise = step & ~clr & ~cnt_reg[ratio] & cnt_next[ratio];

  // internal count, cleared on reset and on demand, never visible on the bus
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= '0;
    else if (clr)
      cnt_reg <= '0;
    else if (step)
      cnt_reg <= cnt_next;
  end

endmodule
`default_nettype wire

// *** testbench/tmrps_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module tmrps_props
  import tmrps_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // system and bus
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic PSLVERR,
  // pin, watchdog and count
  input wire logic EXT_PIN_OE_N,
  input wire logic [5:0] PIN_DIR,
  input wire logic WDOG_TICK,
  input wire logic WDOG_TIMEOUT,
  input wire logic [7:0] COUNT_VALUE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  logic [5:0] idx;
  logic wr;
  logic cnt_wr;
  logic mapped;
  logic on_pin;
  logic [7:0] opt_reg;
  logic [7:0] cmp_reg;
  logic [3:0] quiet_reg;
  // decoded writes; option (which cannot be read back) and comparator control are shadowed here
  assign idx = PADDR[7:2];
  assign wr = PSEL && PENABLE && PWRITE && PSTRB[0];
  assign cnt_wr = wr && idx == TMRPS_IDX_COUNT;
  assign mapped = idx inside {TMRPS_IDX_COUNT, TMRPS_IDX_CMP_SMALL, TMRPS_IDX_CMP_LARGE, TMRPS_IDX_OPTION, TMRPS_IDX_DIR};
  assign on_pin = cmp_reg[4] && !cmp_reg[6];
  // quiet counts cycles since the last write, saturating
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      opt_reg <= TMRPS_OPTION_RST;
      cmp_reg <= TMRPS_CMP_RST;
      quiet_reg <= 4'h0;
    end
    else
    begin
      if (wr && idx == TMRPS_IDX_OPTION)
        opt_reg <= PWDATA[7:0];
      if (wr && (idx == TMRPS_IDX_CMP_SMALL || idx == TMRPS_IDX_CMP_LARGE))
        cmp_reg <= PWDATA[7:0];
      quiet_reg <= wr ? 4'h0 : (quiet_reg == 4'hf ? quiet_reg : quiet_reg + 4'h1);
    end
  end
  sequence s_cnt_write;
    cnt_wr ##1 !wr [*6];
  endsequence
  sequence s_timer_step;
    (!opt_reg[5] && opt_reg[3] && quiet_reg == 4'hf && $changed(COUNT_VALUE)) ##1 !wr [*4];
  endsequence
  a_write_lands: assert property (cnt_wr |=> COUNT_VALUE == $past(PWDATA[7:0]))
    else $error("count does not hold written value");
  a_write_hold: assert property (s_cnt_write |-> COUNT_VALUE == $past(COUNT_VALUE, 5))
    else $error("count moved inside write hold");
  a_count_step: assert property ($changed(COUNT_VALUE) |-> COUNT_VALUE == $past(COUNT_VALUE) + 8'h01 || $past(cnt_wr))
    else $error("count changed by other than one");
  a_timer_tick: assert property (s_timer_step |-> COUNT_VALUE == $past(COUNT_VALUE, 4) + 8'h01 && $past(COUNT_VALUE) == $past(COUNT_VALUE, 4))
    else $error("timer step not every four clocks");
  a_unmapped_err: assert property (PSEL && PENABLE |-> PSLVERR == !mapped)
    else $error("error response wrong for index");
  a_pin_input: assert property (opt_reg[5] && !on_pin |-> EXT_PIN_OE_N && PIN_DIR[TMRPS_DIR_PIN_BIT])
    else $error("count pin not forced to input");
  a_cmp_drive: assert property (opt_reg[5] && on_pin |-> !EXT_PIN_OE_N)
    else $error("comparator not driven on pin");
  a_wdog_pass: assert property (!opt_reg[3] |-> WDOG_TIMEOUT == WDOG_TICK)
    else $error("watchdog got prescaler while counter owns it");
endmodule
bind tmrps_top tmrps_props #(.ADDR_W(ADDR_W)) i_props (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PSLVERR(PSLVERR),
  .EXT_PIN_OE_N(EXT_PIN_OE_N), .PIN_DIR(PIN_DIR), .WDOG_TICK(WDOG_TICK), .WDOG_TIMEOUT(WDOG_TIMEOUT),
  .COUNT_VALUE(COUNT_VALUE));
`default_nettype wire

// *** testbench/tmrps_src_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module tmrps_src_model (
  // clock
  input wire logic clk,
  // source levels
  output logic pin_lvl,
  output logic cmp_lvl
);
  // both sources rest low between bursts
  initial
  begin
    pin_lvl = 1'b0;
    cmp_lvl = 1'b0;
  end
  // move one source after an edge and hold four clocks, enough for the phase sampling
  task automatic level(input logic on_cmp, input logic v);
    @(posedge clk);
    if (on_cmp)
      cmp_lvl <= v;
    else
      pin_lvl <= v;
    repeat (3) @(posedge clk);
  endtask
  // whole pulses only, so each gives one rising and one falling edge
  task automatic pulses(input logic on_cmp, input int n);
    repeat (n)
    begin
      level(on_cmp, 1'b1);
      level(on_cmp, 1'b0);
    end
  endtask
endmodule
`default_nettype wire

// *** testbench/tmrps_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tmrps_tb_top
  import tmrps_pkg::*;
;
  localparam logic [7:0] A_CNT = {TMRPS_IDX_COUNT, 2'b00};
  localparam logic [7:0] A_CMP = {TMRPS_IDX_CMP_LARGE, 2'b00};
  localparam logic [7:0] A_OPT = {TMRPS_IDX_OPTION, 2'b00};
  localparam logic [7:0] A_DIR = {TMRPS_IDX_DIR, 2'b00};
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, port_latch, wd_tick, wd_clear, wd_to;
  logic pin_o, pin_oe_n, pin_lvl, cmp_lvl, pin_wire, err_v;
  logic [7:0] paddr, count;
  logic [31:0] pwdata, prdata, rd_v;
  logic [5:0] pin_dir;
  logic [6:0] cmp_ctl;
  int err_total, tests_run;
  // the pin carries the device's value whenever the device enables its driver
  assign pin_wire = pin_oe_n ? pin_lvl : pin_o;
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  tmrps_top i_dut (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EXT_PIN_I(pin_wire),
    .EXT_PIN_O(pin_o), .EXT_PIN_OE_N(pin_oe_n), .PORT_LATCH(port_latch), .PIN_DIR(pin_dir), .COMP_RESULT(cmp_lvl),
    .COMP_CTRL(cmp_ctl), .WDOG_TICK(wd_tick), .WDOG_CLEAR(wd_clear), .WDOG_TIMEOUT(wd_to), .COUNT_VALUE(count));
  tmrps_src_model i_src (.clk(mclk), .pin_lvl(pin_lvl), .cmp_lvl(cmp_lvl));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one transfer; request held until ready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(what, rd_v, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, well past the longest expected run
  initial
  begin
    repeat (30000) @(posedge mclk);
    err_total++;
    end_sim();
  end
  initial
  begin
    {rst_n, psel, penable, pwrite, port_latch, wd_tick, wd_clear} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    tick(12);
    rst_n <= 1'b1;
    rdc("count", A_CNT, 32'h00000000);
    apb(1'b0, A_CMP, 8'h00);
    chk("comparator ctl", rd_v, 32'h0000007f);
    rdc("option", A_OPT, 32'h00000000);
    apb(1'b0, 8'h3c, 8'h00);
    chk("unmapped error", 32'(err_v), 32'h00000001);
    chk("pin input", 32'({pin_oe_n, pin_dir}), 32'h0000007f);
    $display("test reset done");
    port_latch <= 1'b1;
    apb(1'b1, A_OPT, 8'h08);
    apb(1'b1, A_DIR, 8'h00);
    @(negedge mclk);
    chk("plain port", 32'({pin_oe_n, pin_dir, pin_o}), 32'h00000001);
    apb(1'b1, A_CNT, 8'hfe);
    tick(40);
    rdc("timer count", A_CNT, 32'h00000006);
    $display("test timer done");
    for (int r = 0; r < 8; r++)
    begin
      apb(1'b1, A_OPT, 8'(r));
      apb(1'b1, A_CNT, 8'h00);
      tick(14 << (r + 1));
      apb(1'b0, A_CNT, 8'h00);
      chk("prescaled count", 32'(rd_v[7:0] inside {8'h03, 8'h04}), 32'h00000001);
    end
    wd_tick <= 1'b1;
    @(posedge mclk);
    chk("watchdog pass", 32'(wd_to), 32'h00000001);
    wd_tick <= 1'b0;
    wd_clear <= 1'b1;
    $display("test prescaler done");
    apb(1'b1, A_OPT, 8'h38);
    wd_clear <= 1'b0;
    @(negedge mclk);
    chk("pin forced", 32'({pin_oe_n, pin_dir}), 32'h00000044);
    apb(1'b1, A_CNT, 8'h00);
    tick(10);
    i_src.level(1'b0, 1'b1);
    tick(8);
    rdc("rise ignored", A_CNT, 32'h00000000);
    i_src.level(1'b0, 1'b0);
    tick(8);
    rdc("fall counted", A_CNT, 32'h00000001);
    apb(1'b1, A_OPT, 8'h28);
    i_src.pulses(1'b0, 5);
    tick(8);
    rdc("rise counted", A_CNT, 32'h00000006);
    $display("test pin done");
    apb(1'b1, A_CMP, 8'h68);
    apb(1'b1, A_CNT, 8'h00);
    tick(10);
    i_src.pulses(1'b1, 4);
    i_src.pulses(1'b0, 3);
    apb(1'b1, A_CMP, 8'h28);
    i_src.pulses(1'b1, 2);
    tick(8);
    rdc("internal cmp", A_CNT, 32'h00000006);
    chk("pin released", 32'(pin_oe_n), 32'h00000001);
    chk("comparator bits", 32'(cmp_ctl), 32'h00000028);
    apb(1'b1, A_CMP, 8'h38);
    @(negedge mclk);
    chk("pin driven", 32'(pin_oe_n), 32'h00000000);
    apb(1'b1, A_CNT, 8'h00);
    tick(10);
    i_src.pulses(1'b1, 3);
    tick(8);
    rdc("cmp on pin", A_CNT, 32'h00000003);
    $display("test comparator done");
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    rdc("count again", A_CNT, 32'h00000000);
    rdc("count idle", A_CNT, 32'h00000000);
    $display("test second reset done");
    end_sim();
  end
endmodule
`default_nettype wire
